// ==== design/bsc_boundary_scan_cells.sv ====
/*
  boundary-scan cells of the port pins, two-wire driver, reset pin,
  clock options and analog comparator, with capture/shift/update stages
  on tck and the pad-side muxes on ref_clk.
  assumes: an outside tap controller gives captureDr, shiftDr, updateDr
  and extestSel on tck; the pad wire is resolved outside from pinOut and
  pinOeN.
*/
// Function
// - one two-stage cell per bidirectional pin
// - separate scan cell on pull-up enable
// - sample equals pin level, before synchroniser
// - output value from port, control from direction
// - pull-up only if enabled, input, port one
// - alternate functions outside cell, true pin level
// - analog pins direct, cells on digital side
// - two-wire driver enable on general cell
// - no scan path for spike filter
// - two observe-only cells on reset pin
// - oscillator enable general, clock observe-only
// - timer oscillator scanned, RC oscillator not
// - four pairs, external clock idles at zero
// - other clock lines idle at one
// - oscillator enables controllable from chain
// - general cells on four comparator signals
// - shift least significant bit first
`timescale 1ns/100ps
module bsc_boundary_scan_cells (
  // system clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  // test access side, tck domain
  input  wire logic                       tck,
  input  wire logic                       tapRst,
  input  wire logic                       tdi,
  input  wire logic                       captureDr,
  input  wire logic                       shiftDr,
  input  wire logic                       updateDr,
  input  wire logic                       extestSel,
  output logic                            tdo,
  // port logic, system side
  input  wire logic [bsc_pkg::NPIN-1:0]   portOutputBit,
  input  wire logic [bsc_pkg::NPIN-1:0]   directionBit,
  input  wire logic                       globalPullupDisable,
  output logic      [bsc_pkg::NPIN-1:0]   pinInputRegister,
  // port pads
  input  wire logic [bsc_pkg::NPIN-1:0]   pinIn,
  output logic      [bsc_pkg::NPIN-1:0]   pinOut,
  output logic      [bsc_pkg::NPIN-1:0]   pinOeN,
  output logic      [bsc_pkg::NPIN-1:0]   pinPullupEnable,
  // two-wire slew-limited driver
  input  wire logic                       twoWireEnSys,
  output logic                            twoWireDriverEnable,
  // reset pin
  input  wire logic                       lowVoltageResetN,
  input  wire logic                       highVoltageReset,
  // clock options
  input  wire logic [bsc_pkg::NOSC-1:0]   oscEnableSys,
  input  wire logic [bsc_pkg::NOSC-1:0]   clockLinePad,
  input  wire logic [bsc_pkg::NOSC-1:0]   clockOptionUsed,
  output logic      [bsc_pkg::NOSC-1:0]   oscEnable,
  // analog comparator
  input  wire logic                       cmpOffSys,
  input  wire logic                       cmpMuxSelectSys,
  input  wire logic                       cmpBandgapSys,
  input  wire logic                       comparatorRaw,
  output logic                            comparatorOff,
  output logic                            comparatorMuxSelect,
  output logic                            comparatorBandgapEnable,
  output logic                            comparatorOutput
);
  // ---------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------
  logic [bsc_pkg::CHAIN_LEN-1:0] capSrc;
  logic [bsc_pkg::CHAIN_LEN-1:0] capS1_q;
  logic [bsc_pkg::CHAIN_LEN-1:0] capS2_q;
  logic [bsc_pkg::CHAIN_LEN-1:0] chain_q;
  logic [bsc_pkg::CHAIN_LEN-1:0] chain_d;
  logic [bsc_pkg::CHAIN_LEN-1:0] upd_q;
  logic                          ext_q;
  logic                          tdo_q;
  logic [bsc_pkg::SYNC_LEN-1:0]  syncSrc;
  logic [bsc_pkg::SYNC_LEN-1:0]  rs1_q;
  logic [bsc_pkg::SYNC_LEN-1:0]  rs2_q;
  logic [bsc_pkg::CHAIN_LEN-1:0] updRef;
  logic                          modeOn;
  logic [bsc_pkg::NOSC-1:0]      clkLineScan;
  logic [bsc_pkg::NPIN-1:0]      pullupSys;
  logic [bsc_pkg::NPIN-1:0]      pinOut_d;
  logic [bsc_pkg::NPIN-1:0]      pinOeN_d;
  logic [bsc_pkg::NPIN-1:0]      pinPullup_d;
  logic                          twi_d;
  logic [bsc_pkg::NOSC-1:0]      oscEn_d;
  logic                          cmpOff_d;
  logic                          cmpMux_d;
  logic                          cmpBg_d;
  logic                          cmpOut_d;
  logic [bsc_pkg::NPIN-1:0]      pinOut_q;
  logic [bsc_pkg::NPIN-1:0]      pinOeN_q;
  logic [bsc_pkg::NPIN-1:0]      pinPullup_q;
  logic [bsc_pkg::NPIN-1:0]      pinInReg_q;
  logic                          twi_q;
  logic [bsc_pkg::NOSC-1:0]      oscEn_q;
  logic                          cmpOff_q;
  logic                          cmpMux_q;
  logic                          cmpBg_q;
  logic                          cmpOut_q;

  // ---------------------------------------------------------------------
  // capture sources
  // ---------------------------------------------------------------------
  // unused clock option parks its scanned line at the idle level
  assign clkLineScan = (clockLinePad & clockOptionUsed)
                     | (bsc_pkg::CLK_IDLE_LEVEL & ~clockOptionUsed);
  // what each cell sees at capture
  assign capSrc[bsc_pkg::PU_BASE +: bsc_pkg::NPIN] = pinPullup_q;
  assign capSrc[bsc_pkg::OC_BASE +: bsc_pkg::NPIN] = ~pinOeN_q;
  // raw pad level, alternate functions sit outside, so this is the pin
  assign capSrc[bsc_pkg::OD_BASE +: bsc_pkg::NPIN] = pinIn;
  assign capSrc[bsc_pkg::TWI_POS]                  = twi_q;
  assign capSrc[bsc_pkg::RLV_POS]                  = lowVoltageResetN;
  assign capSrc[bsc_pkg::RHV_POS]                  = highVoltageReset;
  assign capSrc[bsc_pkg::OEN_BASE +: bsc_pkg::NOSC] = oscEn_q;
  assign capSrc[bsc_pkg::OCK_BASE +: bsc_pkg::NOSC] = clkLineScan;
  // comparator digital-side signals, the analog pin itself is not cut
  assign capSrc[bsc_pkg::COFF_POS] = cmpOff_q;
  assign capSrc[bsc_pkg::CMUX_POS] = cmpMux_q;
  assign capSrc[bsc_pkg::CBG_POS]  = cmpBg_q;
  assign capSrc[bsc_pkg::COUT_POS] = comparatorRaw;

  // ---------------------------------------------------------------------
  // tck domain: capture sync, chain, update stage
  // ---------------------------------------------------------------------
  // two-flop sync of capture sources into tck
  always_ff @(posedge tck)
  begin
    if (tapRst)
    begin
      capS1_q <= bsc_pkg::CHAIN_RESET;
      capS2_q <= bsc_pkg::CHAIN_RESET;
    end
    else
    begin
      capS1_q <= capSrc;
      capS2_q <= capS1_q;
    end
  end

  // capture, else shift toward bit 0, else hold
  assign chain_d = captureDr ? capS2_q
                 : shiftDr   ? {tdi, chain_q[bsc_pkg::CHAIN_LEN-1:1]}
                 : chain_q;

  // shift stage of every cell
  always_ff @(posedge tck)
  begin
    if (tapRst)
      chain_q <= bsc_pkg::CHAIN_RESET;
    else
      chain_q <= chain_d;
  end

  // update stage holds until the next update
  always_ff @(posedge tck)
  begin
    if (tapRst)
    begin
      upd_q <= bsc_pkg::UPD_RESET;
      ext_q <= 1'b0;
    end
    else
    begin
      if (updateDr)
        upd_q <= chain_q;
      ext_q <= extestSel;
    end
  end

  // serial out on the falling edge
  always_ff @(negedge tck)
  begin
    if (tapRst)
      tdo_q <= 1'b0;
    else
      tdo_q <= chain_q[0];
  end

  assign tdo = tdo_q;

  // ---------------------------------------------------------------------
  // ref_clk domain: syncs and pad-side muxes
  // ---------------------------------------------------------------------
  // update bits are static between updates, so per-bit sync is safe
  assign syncSrc = {pinIn, comparatorRaw, ext_q, upd_q};

  // two-flop sync into ref_clk
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rs1_q <= bsc_pkg::SYNC_RESET;
      rs2_q <= bsc_pkg::SYNC_RESET;
    end
    else
    begin
      rs1_q <= syncSrc;
      rs2_q <= rs1_q;
    end
  end

  assign updRef = rs2_q[bsc_pkg::CHAIN_LEN-1:0];
  assign modeOn = rs2_q[bsc_pkg::SYNC_EXT];

  // pull-up asked for by the port logic
  assign pullupSys = {bsc_pkg::NPIN{~globalPullupDisable}}
                   & ~directionBit & portOutputBit;

  // pad controls: chain while in extest, else the port registers
  assign pinOut_d    = modeOn ? updRef[bsc_pkg::OD_BASE +: bsc_pkg::NPIN]
                              : portOutputBit;
  assign pinOeN_d    = modeOn ? ~updRef[bsc_pkg::OC_BASE +: bsc_pkg::NPIN]
                              : ~directionBit;
  assign pinPullup_d = modeOn ? updRef[bsc_pkg::PU_BASE +: bsc_pkg::NPIN]
                              : pullupSys;
  assign twi_d       = modeOn ? updRef[bsc_pkg::TWI_POS] : twoWireEnSys;
  assign oscEn_d     = modeOn ? updRef[bsc_pkg::OEN_BASE +: bsc_pkg::NOSC]
                              : oscEnableSys;
  assign cmpOff_d    = modeOn ? updRef[bsc_pkg::COFF_POS] : cmpOffSys;
  assign cmpMux_d    = modeOn ? updRef[bsc_pkg::CMUX_POS] : cmpMuxSelectSys;
  assign cmpBg_d     = modeOn ? updRef[bsc_pkg::CBG_POS]  : cmpBandgapSys;
  assign cmpOut_d    = modeOn ? updRef[bsc_pkg::COUT_POS]
                              : rs2_q[bsc_pkg::SYNC_CMP];

  // pad and analog-side output flops
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pinOut_q    <= bsc_pkg::PIN_RESET;
      pinOeN_q    <= ~bsc_pkg::PIN_RESET;
      pinPullup_q <= bsc_pkg::PIN_RESET;
      pinInReg_q  <= bsc_pkg::PIN_RESET;
      twi_q       <= 1'b0;
      oscEn_q     <= bsc_pkg::OSC_RESET;
      cmpOff_q    <= 1'b1;
      cmpMux_q    <= 1'b0;
      cmpBg_q     <= 1'b0;
      cmpOut_q    <= 1'b0;
    end
    else
    begin
      pinOut_q    <= pinOut_d;
      pinOeN_q    <= pinOeN_d;
      pinPullup_q <= pinPullup_d;
      pinInReg_q  <= rs2_q[bsc_pkg::SYNC_PIN +: bsc_pkg::NPIN];
      twi_q       <= twi_d;
      oscEn_q     <= oscEn_d;
      cmpOff_q    <= cmpOff_d;
      cmpMux_q    <= cmpMux_d;
      cmpBg_q     <= cmpBg_d;
      cmpOut_q    <= cmpOut_d;
    end
  end

  // spike filter stays off the chain; pins keep the plain cells
  assign pinOut                  = pinOut_q;
  assign pinOeN                  = pinOeN_q;
  assign pinPullupEnable         = pinPullup_q;
  assign pinInputRegister        = pinInReg_q;
  assign twoWireDriverEnable     = twi_q;
  assign oscEnable               = oscEn_q;
  assign comparatorOff           = cmpOff_q;
  assign comparatorMuxSelect     = cmpMux_q;
  assign comparatorBandgapEnable = cmpBg_q;
  assign comparatorOutput        = cmpOut_q;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  sequence sCapThenShift;
    captureDr ##1 (shiftDr && !captureDr);
  endsequence

  a_shift_lsb_first:
    assert property (@(posedge tck) disable iff (tapRst)
      shiftDr && !captureDr |=> chain_q[bsc_pkg::CHAIN_LEN-2:0]
        == $past(chain_q[bsc_pkg::CHAIN_LEN-1:1]) && chain_q[bsc_pkg::CHAIN_LEN-1] == $past(tdi))
    else $error("chain did not shift toward bit 0");

  a_capture_first_bit:
    assert property (@(posedge tck) disable iff (tapRst)
      sCapThenShift |-> tdo_q == $past(capS2_q[0])
        ##1 chain_q[bsc_pkg::CHAIN_LEN-2] == $past(capS2_q[bsc_pkg::CHAIN_LEN-1], 2))
    else $error("captured value lost on first shift");

  a_update_holds:
    assert property (@(posedge tck) disable iff (tapRst)
      !updateDr [*2] |=> $stable(upd_q))
    else $error("update stage changed without update");

  a_update_loads:
    assert property (@(posedge tck) disable iff (tapRst)
      updateDr |=> upd_q == $past(chain_q))
    else $error("update stage missed chain contents");

  a_pin_sample_raw:
    assert property (@(posedge tck) disable iff (tapRst)
      captureDr |=> chain_q[bsc_pkg::OD_BASE +: bsc_pkg::NPIN] == $past(pinIn, 3))
    else $error("pin sample not from raw pad through two flops");

  a_normal_map:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      !modeOn |=> pinOut_q == $past(portOutputBit) && pinOeN_q == ~$past(directionBit))
    else $error("pin drive not taken from port and direction");

  a_pullup_expr:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      !modeOn && $past(!modeOn) && !$past(sys_rst) |-> pinPullup_q
        == ($past(portOutputBit) & ~$past(directionBit)
        & {bsc_pkg::NPIN{~$past(globalPullupDisable)}}))
    else $error("pull-up enable expression wrong");

  a_extest_drive:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      modeOn |=> pinOut_q == $past(updRef[bsc_pkg::OD_BASE +: bsc_pkg::NPIN])
        && twi_q == $past(updRef[bsc_pkg::TWI_POS]))
    else $error("extest drive not taken from update stage");

  a_osc_from_chain:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      modeOn |=> oscEnable == $past(updRef[bsc_pkg::OEN_BASE +: bsc_pkg::NOSC]))
    else $error("oscillator enables not chain controlled");

  a_clock_idle_lvl:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      !clockOptionUsed[bsc_pkg::EXT_CLK_IDX] |-> !clkLineScan[bsc_pkg::EXT_CLK_IDX]
        && (clkLineScan[bsc_pkg::TIMER_AUX_IDX] || clockOptionUsed[bsc_pkg::TIMER_AUX_IDX]))
    else $error("idle clock line level wrong");

  a_cmp_cells:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      modeOn |=> comparatorOff == $past(updRef[bsc_pkg::COFF_POS])
        && comparatorOutput == $past(updRef[bsc_pkg::COUT_POS]))
    else $error("comparator cells not applied");
endmodule

// ==== design/bsc_pkg.sv ====
/*
  constants for the boundary-scan cell block: cell positions in the chain,
  crossing vector layout, idle levels and reset values.
  assumes: used as bsc_pkg::name, never imported.
*/
package bsc_pkg;
  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int NPIN = 4;   // scanned port pins, pins 0 and 1 are the two-wire pins
  localparam int NOSC = 4;   // clock options with external connections

  // ---------------------------------------------------------------------
  // chain positions, bit 0 is next out of the chain
  // ---------------------------------------------------------------------
  localparam int PU_BASE   = 0;
  localparam int OC_BASE   = NPIN;
  localparam int OD_BASE   = 2 * NPIN;
  localparam int TWI_POS   = 3 * NPIN;
  localparam int RLV_POS   = TWI_POS + 1;
  localparam int RHV_POS   = TWI_POS + 2;
  localparam int OEN_BASE  = TWI_POS + 3;
  localparam int OCK_BASE  = OEN_BASE + NOSC;
  localparam int COFF_POS  = OCK_BASE + NOSC;
  localparam int CMUX_POS  = COFF_POS + 1;
  localparam int CBG_POS   = COFF_POS + 2;
  localparam int COUT_POS  = COFF_POS + 3;
  localparam int CHAIN_LEN = COUT_POS + 1;

  // ---------------------------------------------------------------------
  // layout of the vector crossing into ref_clk
  // ---------------------------------------------------------------------
  localparam int SYNC_EXT  = CHAIN_LEN;
  localparam int SYNC_CMP  = CHAIN_LEN + 1;
  localparam int SYNC_PIN  = CHAIN_LEN + 2;
  localparam int SYNC_LEN  = SYNC_PIN + NPIN;

  // ---------------------------------------------------------------------
  // clock option index and idle levels of scanned clock lines
  // ---------------------------------------------------------------------
  localparam int EXT_CLK_IDX   = 0;
  localparam int MAIN_XTAL_IDX = 1;
  localparam int LOW_FREQ_IDX  = 2;
  localparam int TIMER_AUX_IDX = 3;
  localparam logic [NOSC-1:0] CLK_IDLE_LEVEL = 4'hE;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = '0;
  localparam logic [CHAIN_LEN-1:0] UPD_RESET   =
    {{(CHAIN_LEN - COFF_POS - 1){1'b0}}, 1'b1, {COFF_POS{1'b0}}};
  localparam logic [SYNC_LEN-1:0]  SYNC_RESET  = '0;
  localparam logic [NPIN-1:0]      PIN_RESET   = '0;
  localparam logic [NOSC-1:0]      OSC_RESET   = '0;
endpackage

// ==== testbench/bsc_tester.sv ====
/*
  tester model: drives the test access side of the scan cells.
  assumes: the bench calls scan and tapReset; tck stands still between frames.
*/
`timescale 1ns/100ps
module bsc_tester (
  // test access side
  output logic      tck,
  output logic      tapRst,
  output logic      tdi,
  output logic      captureDr,
  output logic      shiftDr,
  output logic      updateDr,
  output logic      extestSel,
  input  wire logic tdo
);
  // idle levels, tck parked high so no edge at time zero
  initial
  begin
    {tck, tapRst, tdi, captureDr, shiftDr, updateDr, extestSel} = 7'b100_0000;
  end

  // one tck period, controls move 1 ns after posedge, tdo taken at posedge
  task automatic step(input logic c, s, u, d, output logic o);
    captureDr = c;
    shiftDr = s;
    updateDr = u;
    tdi = s ? d : ~tdi; // unused serial line toggles, never holds old data
    #6.5 tck = 1'b0;
    #7.5 tck = 1'b1;
    o = tdo;
    #1;
  endtask

  // frame: settle, capture, shift whole chain, optional update
  task automatic scan(input logic ext, upd, input logic [bsc_pkg::CHAIN_LEN-1:0] din,
                      output logic [bsc_pkg::CHAIN_LEN-1:0] dout);
    logic o;
    extestSel = ext;
    repeat (4) step(1'b0, 1'b0, 1'b0, 1'b0, o);
    step(1'b1, 1'b0, 1'b0, 1'b0, o);
    for (int k = 0; k < bsc_pkg::CHAIN_LEN; k++)
      step(1'b0, 1'b1, 1'b0, din[k], dout[k]);
    step(1'b0, 1'b0, upd, 1'b0, o);
    step(1'b0, 1'b0, 1'b0, 1'b0, o);
  endtask

  // reset of the tck side, held over three edges
  task automatic tapReset();
    logic o;
    tapRst = 1'b1;
    repeat (3) step(1'b0, 1'b0, 1'b0, 1'b0, o);
    tapRst = 1'b0;
    repeat (3) step(1'b0, 1'b0, 1'b0, 1'b0, o);
  endtask
endmodule

// ==== testbench/test_boundary_scan_cells.sv ====
/*
  testbench: normal port path, then extest frames through the tester model.
  assumes: pads resolved here from pinOut, pinOeN and an outside level.
*/
`timescale 1ns/100ps
module test_boundary_scan_cells;
  typedef logic [bsc_pkg::CHAIN_LEN-1:0] bsc_vec_t;
  logic       ref_clk, sys_rst, tck, tapRst, tdi, captureDr, shiftDr, updateDr, extestSel, tdo;
  logic [3:0] portOutputBit, directionBit, pinInputRegister, pinIn, pinOut, pinOeN;
  logic [3:0] pinPullupEnable, pinExt, oscEnableSys, clockLinePad, clockOptionUsed, oscEnable;
  logic       globalPullupDisable, twoWireEnSys, twoWireDriverEnable, lowVoltageResetN;
  logic       highVoltageReset, cmpOffSys, cmpMuxSelectSys, cmpBandgapSys, comparatorRaw;
  logic       comparatorOff, comparatorMuxSelect, comparatorBandgapEnable, comparatorOutput;
  int         badCount, compares, cycles;
  bsc_vec_t   v1, v2;

  // -----------------------------------------------------------------
  // clock, pads, instances
  // -----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  assign pinIn = (~pinOeN & pinOut) | (pinOeN & pinExt);

  bsc_tester tap (.tck(tck), .tapRst(tapRst), .tdi(tdi), .captureDr(captureDr),
    .shiftDr(shiftDr), .updateDr(updateDr), .extestSel(extestSel), .tdo(tdo));

  bsc_boundary_scan_cells uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck),
    .tapRst(tapRst), .tdi(tdi), .captureDr(captureDr), .shiftDr(shiftDr),
    .updateDr(updateDr), .extestSel(extestSel), .tdo(tdo), .portOutputBit(portOutputBit),
    .directionBit(directionBit), .globalPullupDisable(globalPullupDisable),
    .pinInputRegister(pinInputRegister), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
    .pinPullupEnable(pinPullupEnable), .twoWireEnSys(twoWireEnSys),
    .twoWireDriverEnable(twoWireDriverEnable), .lowVoltageResetN(lowVoltageResetN),
    .highVoltageReset(highVoltageReset), .oscEnableSys(oscEnableSys),
    .clockLinePad(clockLinePad), .clockOptionUsed(clockOptionUsed), .oscEnable(oscEnable),
    .cmpOffSys(cmpOffSys), .cmpMuxSelectSys(cmpMuxSelectSys), .cmpBandgapSys(cmpBandgapSys),
    .comparatorRaw(comparatorRaw), .comparatorOff(comparatorOff),
    .comparatorMuxSelect(comparatorMuxSelect),
    .comparatorBandgapEnable(comparatorBandgapEnable), .comparatorOutput(comparatorOutput));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      badCount++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // builds a chain image from its driven fields
  function automatic bsc_vec_t mkVec(input logic [3:0] pu, oc, od, osc,
                                     input logic twi, coff, mux, bg);
    bsc_vec_t v;
    v = '0;
    v[bsc_pkg::PU_BASE +: 4] = pu;
    v[bsc_pkg::OC_BASE +: 4] = oc;
    v[bsc_pkg::OD_BASE +: 4] = od;
    v[bsc_pkg::OEN_BASE +: 4] = osc;
    v[bsc_pkg::TWI_POS] = twi;
    v[bsc_pkg::COFF_POS] = coff;
    v[bsc_pkg::CMUX_POS] = mux;
    v[bsc_pkg::CBG_POS] = bg;
    v[bsc_pkg::COUT_POS] = ~coff;
    return v;
  endfunction

  // outputs driven from the update stage
  task automatic checkPads(input bsc_vec_t v);
    tick(6);
    chk("pullup", v[bsc_pkg::PU_BASE +: 4], pinPullupEnable);
    chk("oen", v[bsc_pkg::OC_BASE +: 4] ^ 4'hF, pinOeN);
    chk("out", v[bsc_pkg::OD_BASE +: 4], pinOut);
    chk("twi", v[bsc_pkg::TWI_POS], twoWireDriverEnable);
    chk("osc", v[bsc_pkg::OEN_BASE +: 4], oscEnable);
    chk("cmp", v[bsc_pkg::CBG_POS:bsc_pkg::COFF_POS],
        {comparatorBandgapEnable, comparatorMuxSelect, comparatorOff});
    chk("cmpOut", v[bsc_pkg::COUT_POS], comparatorOutput);
  endtask

  // one frame, then the captured observe fields
  task automatic scanChk(input logic upd, input bsc_vec_t v, input logic [3:0] expPin);
    bsc_vec_t d;
    tap.scan(1'b1, upd, v, d);
    chk("capPin", expPin, d[bsc_pkg::OD_BASE +: 4]);
    chk("capRst", {highVoltageReset, lowVoltageResetN},
        d[bsc_pkg::RHV_POS:bsc_pkg::RLV_POS]);
    chk("capClk", (clockOptionUsed & clockLinePad) | (~clockOptionUsed & 4'hE),
        d[bsc_pkg::OCK_BASE +: 4]);
    chk("capCmp", comparatorRaw, d[bsc_pkg::COUT_POS]);
  endtask

  task automatic testDone();
    if (badCount == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // cycle ceiling against a hang
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      badCount++;
      testDone();
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    {badCount, compares, cycles} = '0;
    {sys_rst, portOutputBit, directionBit, globalPullupDisable} = {1'b1, 9'h000};
    {twoWireEnSys, oscEnableSys, cmpOffSys, cmpMuxSelectSys, cmpBandgapSys} = '0;
    {pinExt, clockLinePad, clockOptionUsed} = 12'h9_63;
    {lowVoltageResetN, highVoltageReset, comparatorRaw} = 3'h5;
    // tck side is reset while sys_rst holds, so no unknown crosses over
    fork
      #2 tap.tapReset();
    join_none
    tick(11);
    chk("rstOen", 4'hF, pinOeN);
    chk("rstOff", 1'b1, comparatorOff);
    chk("rstRest", 14'h0000,
        {pinOut, pinPullupEnable, twoWireDriverEnable, oscEnable, comparatorOutput});
    tick(1);
    sys_rst = 1'b0;
    // normal path: pads and controls follow the port logic
    for (int i = 0; i < 8; i++)
    begin
      portOutputBit = 4'(i * 3);
      directionBit = 4'(i * 5);
      pinExt = 4'(i * 7);
      {globalPullupDisable, twoWireEnSys, oscEnableSys} = {i[2], i[0], 4'(i)};
      {cmpOffSys, cmpMuxSelectSys, cmpBandgapSys} = i[2:0];
      comparatorRaw = i[1];
      tick(6);
      chk("cmpOut", comparatorRaw, comparatorOutput);
      chk("out", portOutputBit, pinOut);
      chk("oen", directionBit ^ 4'hF, pinOeN);
      chk("pullup", ~directionBit & portOutputBit & {4{~globalPullupDisable}},
          pinPullupEnable);
      chk("inReg", (directionBit & portOutputBit) | (~directionBit & pinExt),
          pinInputRegister);
      chk("twiSys", twoWireEnSys, twoWireDriverEnable);
      chk("oscSys", oscEnableSys, oscEnable);
      chk("cmpSys", {cmpOffSys, cmpMuxSelectSys, cmpBandgapSys},
          {comparatorOff, comparatorMuxSelect, comparatorBandgapEnable});
    end
    directionBit = 4'h0;
    pinExt = 4'h9;
    // extest: no pin drives while its two-wire driver is on, one clock source
    v1 = mkVec(4'h5, 4'hC, 4'hA, 4'h4, 1'b1, 1'b1, 1'b0, 1'b0);
    v2 = mkVec(4'hA, 4'h3, 4'h5, 4'h1, 1'b0, 1'b0, 1'b1, 1'b1);
    scanChk(1'b1, v1, pinExt);
    checkPads(v1);
    {clockOptionUsed, clockLinePad} = 8'h0F;
    {lowVoltageResetN, highVoltageReset, comparatorRaw} = 3'h2;
    scanChk(1'b1, v2, (4'hC & 4'hA) | (4'h3 & pinExt));
    checkPads(v2);
    scanChk(1'b0, v1, (4'h3 & 4'h5) | (4'hC & pinExt));
    checkPads(v2);
    tap.tapReset();
    checkPads(mkVec(4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    testDone();
  end
endmodule
